// >>> hw/lllc_regs.vh
/*
 constants for the layer-1 loopback control block: register offsets,
 field positions, reset values and command codes.
 assumes byte addresses on a 32-bit AXI4-Lite bus, one word per register.

*/
`ifndef LLLC_REGS_VH
`define LLLC_REGS_VH

`define LLLC_OFF_LOOP 8'h00
`define LLLC_OFF_S_CMD 8'h04
`define LLLC_OFF_S_CONFIG_REG0 8'h08
`define LLLC_OFF_S_CONFIG_REG2 8'h0C
`define LLLC_OFF_U_CTRL 8'h10
`define LLLC_OFF_STATUS 8'h14

`define LLLC_LOOP_B1 0
`define LLLC_LOOP_B2 1
`define LLLC_LOOP_ALL 2
`define LLLC_LOOP_TO_U 3
`define LLLC_LOOP_NTRANS 4
`define LLLC_LOOP_DLB 5
`define LLLC_SCMD_ALOOP 0
`define LLLC_SCMD_SM_DIS 1
`define LLLC_SC0_EXLOOP 0
`define LLLC_SC0_DIS_TR 1
`define LLLC_SC2_TRANSMIT_DISABLE_BIT 0
`define LLLC_UCTL_SELF 0
`define LLLC_UCTL_OPEN 1

`define LLLC_RST_LOOP 6'h00
`define LLLC_RST_S_CMD 2'h0
`define LLLC_RST_S_CONFIG_REG0 2'h0
`define LLLC_RST_S_CONFIG_REG2 1'h1

`define LLLC_CODE_ARL 4'hA
`define LLLC_CODE_AIL 4'hE
`define LLLC_EOC_OPEN 2'h0
`define LLLC_EOC_ALL 2'h1
`define LLLC_EOC_B1 2'h2
`define LLLC_EOC_B2 2'h3

`define LLLC_RESP_OKAY 2'h0
`define LLLC_RESP_SLVERR 2'h2

`endif

// >>> hw/lllc_top.v
/*
 layer-1 loopback control: steers B1, B2 and D channel words between the
 U deframer/framer and the S transmitter/receiver,
 with AXI4-Lite registers for the local loops.
 assumes frame_tick, channel data and command strobes come from logic on
 aclk; only the S line level detect arrives from a pin.
*/
`timescale 1ns/100ps
`include "lllc_regs.vh"
`default_nettype none

module lllc_top #(
	parameter BW = 8,
	parameter DW = 2
) (
	// clock and reset
	input wire aclk,
	input wire aresetn,
	// axi4-lite write address
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	// axi4-lite write data
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	// axi4-lite write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// axi4-lite read
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// frame timing
	input wire frame_tick,
	// u deframer side
	input wire [BW-1:0] u_rx_b1,
	input wire [BW-1:0] u_rx_b2,
	input wire [DW-1:0] u_rx_d,
	// u framer side
	output reg [BW-1:0] u_tx_b1,
	output reg [BW-1:0] u_tx_b2,
	output reg [DW-1:0] u_tx_d,
	// s receiver side
	input wire [BW-1:0] s_rx_b1,
	input wire [BW-1:0] s_rx_b2,
	input wire [DW-1:0] s_rx_d,
	// s transmitter side
	output reg [BW-1:0] s_tx_b1,
	output reg [BW-1:0] s_tx_b2,
	output reg [DW-1:0] s_tx_d,
	// s line control and level pin
	output reg s_tx_enable,
	output reg s_level_det_enable,
	input wire s_level_pin,
	output reg not_synchronous_indication,
	// u transceiver control
	input wire u_reset,
	input wire u_ci_valid,
	input wire [3:0] u_ci_code,
	output reg u_analog_loop,
	output reg framer_digital_loop,
	input wire u_transparent_state,
	// s command/indication channel
	input wire s_ci_valid,
	input wire [3:0] s_ci_code,
	// maintenance channel
	input wire eoc_valid,
	input wire [1:0] eoc_code,
	input wire eoc_auto,
	// downstream command forward
	output reg ds_ci_valid,
	output reg [3:0] ds_ci_code
);

localparam [BW-1:0] ONES_B = {BW{1'b1}};
localparam [DW-1:0] ONES_D = {DW{1'b1}};

// register file
reg [5:0] loop_cfg;
reg [1:0] s_cmd;
reg [1:0] s_config_reg0;
reg s_config_reg2;
reg u_ctrl_self;
reg open_pulse;

// loop state
reg l2_all;
reg l2_b1;
reg l2_b2;
reg u_was_reset;
reg s_ci_loop;
reg lvl_meta;
reg lvl_sync;

// axi holding state
reg aw_hold;
reg w_hold;
reg [7:0] aw_addr;
reg [7:0] w_byte0;
reg w_lane0;

wire transmit_disable_bit = s_config_reg2;
wire external_loop_bit = s_config_reg0[`LLLC_SC0_EXLOOP];
wire s_tr_off = s_config_reg0[`LLLC_SC0_DIS_TR];
wire analog_loop_bit = s_cmd[`LLLC_SCMD_ALOOP];
wire sm_disabled = s_cmd[`LLLC_SCMD_SM_DIS];

wire s_loop = s_ci_loop | (analog_loop_bit & sm_disabled);
wire s_int_loop = s_loop & ~external_loop_bit;
wire s_ext_loop = s_loop & external_loop_bit;

wire cfg_all = loop_cfg[`LLLC_LOOP_ALL];
wire cfg_b1 = loop_cfg[`LLLC_LOOP_B1] | cfg_all;
wire cfg_b2 = loop_cfg[`LLLC_LOOP_B2] | cfg_all;
wire cfg_to_u = loop_cfg[`LLLC_LOOP_TO_U];
wire cfg_ntr = loop_cfg[`LLLC_LOOP_NTRANS];
wire cfg_dlb = loop_cfg[`LLLC_LOOP_DLB];

// loops turning data back towards the u line
wire ul_b1 = l2_all | l2_b1 | (cfg_b1 & cfg_to_u);
wire ul_b2 = l2_all | l2_b2 | (cfg_b2 & cfg_to_u);
wire ul_d = l2_all | (cfg_all & cfg_to_u);
// loops turning data back towards the system side
wire il_b1 = (cfg_b1 & ~cfg_to_u) | s_int_loop;
wire il_b2 = (cfg_b2 & ~cfg_to_u) | s_int_loop;
wire il_d = (cfg_all & ~cfg_to_u) | s_int_loop;
// non-transparent register loops replace forwarded data by ones
wire nu_b1 = cfg_ntr & cfg_b1 & cfg_to_u;
wire nu_b2 = cfg_ntr & cfg_b2 & cfg_to_u;
wire nu_d = cfg_ntr & cfg_all & cfg_to_u;
wire ni_b1 = cfg_ntr & cfg_b1 & ~cfg_to_u;
wire ni_b2 = cfg_ntr & cfg_b2 & ~cfg_to_u;
wire ni_d = cfg_ntr & cfg_all & ~cfg_to_u;

// u receive after analog or framer loop: line data ignored
wire u_back = u_analog_loop | framer_digital_loop;
wire [BW-1:0] ur_b1 = u_back ? u_tx_b1 : u_rx_b1;
wire [BW-1:0] ur_b2 = u_back ? u_tx_b2 : u_rx_b2;
wire [DW-1:0] ur_d = u_back ? u_tx_d : u_rx_d;
// s receive: internal loop ignores the pins, external loop comes back on them
wire [BW-1:0] sr_b1 = s_int_loop ? s_tx_b1 : s_rx_b1;
wire [BW-1:0] sr_b2 = s_int_loop ? s_tx_b2 : s_rx_b2;
wire [DW-1:0] sr_d = s_int_loop ? s_tx_d : s_rx_d;

// direct paths pass one frame register; the u analog/framer and s internal loops read back an output register and add a frame
always @(posedge aclk) begin
	if (!aresetn) begin
		u_tx_b1 <= ONES_B;
		u_tx_b2 <= ONES_B;
		u_tx_d <= ONES_D;
		s_tx_b1 <= ONES_B;
		s_tx_b2 <= ONES_B;
		s_tx_d <= ONES_D;
	end else if (frame_tick) begin
		u_tx_b1 <= ul_b1 ? ur_b1 : (ni_b1 ? ONES_B : sr_b1);
		u_tx_b2 <= ul_b2 ? ur_b2 : (ni_b2 ? ONES_B : sr_b2);
		u_tx_d <= ul_d ? ur_d : (ni_d ? ONES_D : sr_d);
		s_tx_b1 <= il_b1 ? sr_b1 : (nu_b1 ? ONES_B : ur_b1);
		s_tx_b2 <= il_b2 ? sr_b2 : (nu_b2 ? ONES_B : ur_b2);
		s_tx_d <= il_d ? sr_d : (nu_d ? ONES_D : ur_d);
	end
end

// s line control and level detector
// the level pin is asynchronous: two flip-flops come before anything reads it
// control outputs lag their register bits by one edge so every output stays a flip-flop
always @(posedge aclk) begin
	if (!aresetn) begin
		lvl_meta <= 1'b0;
		lvl_sync <= 1'b0;
		s_tx_enable <= 1'b0;
		s_level_det_enable <= 1'b0;
		not_synchronous_indication <= 1'b0;
	end else begin
		lvl_meta <= s_level_pin;
		lvl_sync <= lvl_meta;
		s_tx_enable <= ~transmit_disable_bit & ~s_tr_off;
		s_level_det_enable <= ~s_tr_off & ~s_ext_loop;
		// flag only; the loop path above never looks at it
		not_synchronous_indication <= s_int_loop & ~s_tr_off & lvl_sync;
	end
end

// s loop command channel
always @(posedge aclk) begin
	if (!aresetn) begin
		s_ci_loop <= 1'b0;
	end else if (s_ci_valid) begin
		s_ci_loop <= (s_ci_code == `LLLC_CODE_ARL);
	end
end

// u analog and framer loops
// software has no direct open for the analog loop: only a u reset opens it,
// so the echo and equalizer settings always retrain on the next activation
always @(posedge aclk) begin
	if (!aresetn) begin
		u_analog_loop <= 1'b0;
		u_was_reset <= 1'b0;
		framer_digital_loop <= 1'b0;
	end else begin
		framer_digital_loop <= cfg_dlb;
		if (u_reset) begin
			u_analog_loop <= 1'b0;
			u_was_reset <= 1'b1;
		end else if (u_ci_valid && u_ci_code == `LLLC_CODE_ARL && u_was_reset) begin
			// closing without a prior reset would leave stale echo coefficients
			u_analog_loop <= 1'b1;
			u_was_reset <= 1'b0;
		end
	end
end

// loop 2 latches and downstream forwarding
// latches hold until opened; a u reset drops them too, since the line restarts
always @(posedge aclk) begin
	if (!aresetn) begin
		l2_all <= 1'b0;
		l2_b1 <= 1'b0;
		l2_b2 <= 1'b0;
		ds_ci_valid <= 1'b0;
		ds_ci_code <= 4'h0;
	end else begin
		ds_ci_valid <= 1'b0;
		if (u_reset || open_pulse || (eoc_valid && eoc_code == `LLLC_EOC_OPEN)) begin
			l2_all <= 1'b0;
			l2_b1 <= 1'b0;
			l2_b2 <= 1'b0;
		end
		// a close arriving with the software open still wins
		if (eoc_valid && !u_reset) begin
			case (eoc_code)
			`LLLC_EOC_ALL: begin
				if (eoc_auto && !u_ctrl_self) begin
					ds_ci_valid <= 1'b1;
					ds_ci_code <= u_transparent_state ? `LLLC_CODE_AIL : `LLLC_CODE_ARL;
				end else begin
					l2_all <= 1'b1;
				end
			end
			`LLLC_EOC_B1: l2_b1 <= 1'b1;
			`LLLC_EOC_B2: l2_b2 <= 1'b1;
			default: ;
			endcase
		end
	end
end

// read mux
// unmapped offsets answer with an error so a wrong address shows up at once
reg [31:0] rd_word;
reg rd_ok;
always @* begin
	rd_word = 32'h0000_0000;
	rd_ok = 1'b1;
	case (s_axi_araddr)
	`LLLC_OFF_LOOP: rd_word[5:0] = loop_cfg;
	`LLLC_OFF_S_CMD: rd_word[1:0] = s_cmd;
	`LLLC_OFF_S_CONFIG_REG0: rd_word[1:0] = s_config_reg0;
	`LLLC_OFF_S_CONFIG_REG2: rd_word[0] = s_config_reg2;
	`LLLC_OFF_U_CTRL: rd_word[0] = u_ctrl_self;
	`LLLC_OFF_STATUS: rd_word[7:0] = {u_was_reset, not_synchronous_indication,
		s_ext_loop, s_int_loop, u_analog_loop, l2_b2, l2_b1, l2_all};
	default: rd_ok = 1'b0;
	endcase
end

// axi read channel: answer on the same edge that takes the address
always @(posedge aclk) begin
	if (!aresetn) begin
		s_axi_arready <= 1'b1;
		s_axi_rvalid <= 1'b0;
		s_axi_rdata <= 32'h0000_0000;
		s_axi_rresp <= `LLLC_RESP_OKAY;
	end else if (s_axi_rvalid) begin
		if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end else if (s_axi_arvalid && s_axi_arready) begin
		s_axi_arready <= 1'b0;
		s_axi_rvalid <= 1'b1;
		s_axi_rdata <= rd_word;
		s_axi_rresp <= rd_ok ? `LLLC_RESP_OKAY : `LLLC_RESP_SLVERR;
	end
end

// axi write channel; fields live in byte lane 0 only
// the response waits for both halves, so address and data may arrive in either order;
// readies stay low until the response is taken, which limits us to one write at a time
wire do_write = aw_hold & w_hold & ~s_axi_bvalid;
wire wr_ok = (aw_addr == `LLLC_OFF_LOOP) || (aw_addr == `LLLC_OFF_S_CMD) ||
	(aw_addr == `LLLC_OFF_S_CONFIG_REG0) || (aw_addr == `LLLC_OFF_S_CONFIG_REG2) ||
	(aw_addr == `LLLC_OFF_U_CTRL) || (aw_addr == `LLLC_OFF_STATUS);

always @(posedge aclk) begin
	if (!aresetn) begin
		s_axi_awready <= 1'b1;
		s_axi_wready <= 1'b1;
		s_axi_bvalid <= 1'b0;
		s_axi_bresp <= `LLLC_RESP_OKAY;
		aw_hold <= 1'b0;
		w_hold <= 1'b0;
		aw_addr <= 8'h00;
		w_byte0 <= 8'h00;
		w_lane0 <= 1'b0;
	end else begin
		if (s_axi_awvalid && s_axi_awready) begin
			s_axi_awready <= 1'b0;
			aw_hold <= 1'b1;
			aw_addr <= s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			s_axi_wready <= 1'b0;
			w_hold <= 1'b1;
			w_byte0 <= s_axi_wdata[7:0];
			w_lane0 <= s_axi_wstrb[0];
		end
		if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_ok ? `LLLC_RESP_OKAY : `LLLC_RESP_SLVERR;
		end
		if (s_axi_bvalid && s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
			aw_hold <= 1'b0;
			w_hold <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
		end
	end
end

// register storage; status is read-only and ignores writes
always @(posedge aclk) begin
	if (!aresetn) begin
		loop_cfg <= `LLLC_RST_LOOP;
		s_cmd <= `LLLC_RST_S_CMD;
		s_config_reg0 <= `LLLC_RST_S_CONFIG_REG0;
		s_config_reg2 <= `LLLC_RST_S_CONFIG_REG2;
		u_ctrl_self <= 1'b0;
		open_pulse <= 1'b0;
	end else begin
		open_pulse <= 1'b0;
		if (do_write && w_lane0) begin
			case (aw_addr)
			`LLLC_OFF_LOOP: loop_cfg <= w_byte0[5:0];
			`LLLC_OFF_S_CMD: s_cmd <= w_byte0[1:0];
			`LLLC_OFF_S_CONFIG_REG0: s_config_reg0 <= w_byte0[1:0];
			`LLLC_OFF_S_CONFIG_REG2: s_config_reg2 <= w_byte0[`LLLC_SC2_TRANSMIT_DISABLE_BIT];
			`LLLC_OFF_U_CTRL: begin
				u_ctrl_self <= w_byte0[`LLLC_UCTL_SELF];
				open_pulse <= w_byte0[`LLLC_UCTL_OPEN];
			end
			default: ;
			endcase
		end
	end
end

endmodule // lllc_top

`default_nettype wire

// >>> verification/lllc_far.sv
/*
 far-side model: U deframer and S receiver sending one word set per frame.
 assumes the same clock as the block; data changes on the same edge that raises frame_tick.
*/
`timescale 1ns/100ps
`default_nettype none
module lllc_far (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// frame and channel data
	output var logic frame_tick,
	output wire logic [7:0] u_rx_b1,
	output wire logic [7:0] u_rx_b2,
	output wire logic [1:0] u_rx_d,
	output wire logic [7:0] s_rx_b1,
	output wire logic [7:0] s_rx_b2,
	output wire logic [1:0] s_rx_d
);
	logic [1:0] ph;
	logic [7:0] n;
	// channels differ except u_rx_b2 = s_rx_b2 when n & 8'h55 is 8'h11, and s_rx_b1 = s_rx_b2 at n 8'h66 and 8'hE6
	assign u_rx_b1 = n;
	assign u_rx_b2 = n ^ 8'h55;
	assign u_rx_d = n[1:0];
	assign s_rx_b1 = ~n;
	assign s_rx_b2 = n + 8'h33;
	assign s_rx_d = ~n[1:0];
	always @(posedge aclk) begin
		if (!aresetn) begin
			ph <= 2'h0;
			n <= 8'h10;
			frame_tick <= 1'b0;
		end else begin
			ph <= ph + 2'h1;
			frame_tick <= (ph == 2'h3);
			if (ph == 2'h3)
				n <= n + 8'h01;
		end
	end
endmodule // lllc_far
`default_nettype wire

// >>> verification/lllc_props.sv
/*
 assertions on the ports of lllc_top.
 assumes one clock aclk and the synchronous active-low reset aresetn.
*/
`timescale 1ns/100ps
`include "lllc_regs.vh"
`default_nettype none
module lllc_props (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// observed ports
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_tx_enable,
	input wire logic s_level_det_enable,
	input wire logic not_synchronous_indication,
	input wire logic u_reset,
	input wire logic u_ci_valid,
	input wire logic u_analog_loop,
	input wire logic u_transparent_state,
	input wire logic eoc_valid,
	input wire logic [1:0] eoc_code,
	input wire logic eoc_auto,
	input wire logic ds_ci_valid,
	input wire logic [3:0] ds_ci_code
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_txdis_reset: assert property ($rose(aresetn) |=> !s_tx_enable)
		else $error("transmitter on after reset");
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped early");
	a_fwd_code: assert property (ds_ci_valid |->
		ds_ci_code == ($past(u_transparent_state) ? `LLLC_CODE_AIL : `LLLC_CODE_ARL))
		else $error("wrong forwarded loop code");
	a_fwd_cause: assert property (ds_ci_valid |-> $past(eoc_valid) && $past(eoc_auto) &&
		$past(eoc_code) == `LLLC_EOC_ALL) else $error("forward without loop request");
	a_uloop_open: assert property (u_reset |-> ##[1:2] !u_analog_loop)
		else $error("analog loop kept through reset");
	a_uloop_cause: assert property ($rose(u_analog_loop) |-> $past(u_ci_valid) || $past(u_ci_valid, 2))
		else $error("analog loop closed without command");
	a_l2_noreset: assert property (eoc_valid && u_analog_loop && !u_reset && !$past(u_reset) |=> u_analog_loop)
		else $error("maintenance command disturbed analog loop");
	a_nsync_det: assert property (not_synchronous_indication |-> s_level_det_enable)
		else $error("level reported with detector off");
endmodule // lllc_props
bind lllc_top lllc_props u_lllc_props (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready, .s_tx_enable,
	.s_level_det_enable, .not_synchronous_indication, .u_reset, .u_ci_valid, .u_analog_loop,
	.u_transparent_state, .eoc_valid, .eoc_code, .eoc_auto, .ds_ci_valid, .ds_ci_code);
`default_nettype wire

// >>> verification/lllc_top_tb.sv
/*
 self-checking bench for lllc_top: axi4-lite master, command pulses, frame checks.
 assumes lllc_far supplies frame ticks and channel data.
*/
`timescale 1ns/100ps
`include "lllc_regs.vh"
`default_nettype none
module lllc_top_tb;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, frame_tick, s_tx_enable, s_level_det_enable;
	logic s_level_pin, not_synchronous_indication, u_reset, u_ci_valid, u_analog_loop, framer_digital_loop;
	logic u_transparent_state, s_ci_valid, eoc_valid, eoc_auto, ds_ci_valid;
	logic [7:0] s_axi_awaddr, s_axi_araddr, u_rx_b1, u_rx_b2, u_tx_b1, u_tx_b2, s_rx_b1, s_rx_b2, s_tx_b1, s_tx_b2;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb, u_ci_code, s_ci_code, ds_ci_code;
	logic [1:0] s_axi_bresp, s_axi_rresp, u_rx_d, s_rx_d, u_tx_d, s_tx_d, eoc_code, rr, csd;
	logic [7:0] cu, cs, cs2, pu, ps;
	integer n_fail, checks_done;
	lllc_top u_lllc_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .frame_tick,
		.u_rx_b1, .u_rx_b2, .u_rx_d, .u_tx_b1, .u_tx_b2, .u_tx_d, .s_rx_b1, .s_rx_b2, .s_rx_d, .s_tx_b1, .s_tx_b2,
		.s_tx_d, .s_tx_enable, .s_level_det_enable, .s_level_pin, .not_synchronous_indication, .u_reset,
		.u_ci_valid, .u_ci_code, .u_analog_loop, .framer_digital_loop, .u_transparent_state, .s_ci_valid,
		.s_ci_code, .eoc_valid, .eoc_code, .eoc_auto, .ds_ci_valid, .ds_ci_code);
	lllc_far u_lllc_far (.aclk, .aresetn, .frame_tick, .u_rx_b1, .u_rx_b2, .u_rx_d, .s_rx_b1, .s_rx_b2, .s_rx_d);
	task conclude;
		$display("comparisons %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task chk(input [31:0] seen, input [31:0] exp);
		checks_done = checks_done + 1;
		if (seen !== exp) begin
			n_fail = n_fail + 1;
			$display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task axw(input [7:0] a, input [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_awvalid | s_axi_wvalid);
		do @(posedge aclk); while (!s_axi_bvalid);
		rr = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task axr(input [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_rvalid);
		rd = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	// k selects the strobe: 0 u command, 1 s command, 2 maintenance, 3 u reset
	task pls(input integer k, input [3:0] c);
		@(posedge aclk);
		case (k)
			0: begin u_ci_valid <= 1'b1; u_ci_code <= c; end
			1: begin s_ci_valid <= 1'b1; s_ci_code <= c; end
			2: begin eoc_valid <= 1'b1; eoc_code <= c[1:0]; end
			default: u_reset <= 1'b1;
		endcase
		@(posedge aclk);
		{u_ci_valid, s_ci_valid, eoc_valid, u_reset} <= 4'h0;
		repeat (4) @(posedge aclk);
	endtask
	// capture inputs and prior outputs at a tick, return once the outputs moved
	task frm;
		@(negedge aclk);
		while (frame_tick !== 1'b1) @(negedge aclk);
		{cu, cs, cs2, csd, pu, ps} = {u_rx_b1, s_rx_b1, s_rx_b2, s_rx_d, u_tx_b1, s_tx_b1};
		@(posedge aclk);
		#1;
	endtask
	task t_reset;
		axr(`LLLC_OFF_S_CONFIG_REG2);
		chk(rd, 32'h0000_0001);
		chk(s_tx_enable, 1'b0);
		axr(8'h18);
		chk(rr, `LLLC_RESP_SLVERR);
		axw(8'h18, 32'h0000_0001);
		chk(rr, `LLLC_RESP_SLVERR);
		$display("t_reset done");
	endtask
	task t_regloop;
		frm;
		chk(s_tx_b1, cu);
		chk(u_tx_b1, cs);
		chk(s_tx_b2, cu ^ 8'h55);
		chk(s_tx_d, cu[1:0]);
		axw(`LLLC_OFF_LOOP, 32'h0000_0009);
		chk(rr, `LLLC_RESP_OKAY);
		frm;
		chk(u_tx_b1, cu);
		chk(s_tx_b1, cu);
		chk(u_tx_b2, cs2);
		axw(`LLLC_OFF_LOOP, 32'h0000_0019);
		frm;
		chk(s_tx_b1, 8'hff);
		axw(`LLLC_OFF_LOOP, 32'h0000_0004);
		frm;
		chk(s_tx_b1, cs);
		chk(u_tx_d, csd);
		axw(`LLLC_OFF_LOOP, 32'h0000_0020);
		frm;
		chk(framer_digital_loop, 1'b1);
		frm;
		chk(s_tx_b1, pu);
		axw(`LLLC_OFF_LOOP, 32'h0000_0000);
		$display("t_regloop done");
	endtask
	task t_sloop;
		pls(1, `LLLC_CODE_ARL);
		frm;
		chk(s_tx_b1, ps);
		chk(u_tx_b1, ps);
		s_level_pin <= 1'b1;
		repeat (6) @(posedge aclk);
		chk(not_synchronous_indication, 1'b1);
		axw(`LLLC_OFF_S_CONFIG_REG2, 32'h0000_0000);
		@(posedge aclk);
		chk(s_tx_enable, 1'b1);
		axw(`LLLC_OFF_S_CONFIG_REG0, 32'h0000_0001);
		axr(`LLLC_OFF_STATUS);
		chk(rd[5:4], 2'h2);
		chk(s_level_det_enable, 1'b0);
		pls(1, 4'h0);
		s_level_pin <= 1'b0;
		axw(`LLLC_OFF_S_CONFIG_REG0, 32'h0000_0000);
		axw(`LLLC_OFF_S_CMD, 32'h0000_0003);
		axr(`LLLC_OFF_STATUS);
		chk(rd[4], 1'b1);
		axw(`LLLC_OFF_S_CMD, 32'h0000_0000);
		$display("t_sloop done");
	endtask
	task t_uloop;
		pls(0, `LLLC_CODE_ARL);
		chk(u_analog_loop, 1'b0);
		pls(3, 4'h0);
		pls(0, `LLLC_CODE_ARL);
		chk(u_analog_loop, 1'b1);
		frm;
		chk(s_tx_b1, pu);
		chk(u_tx_b1, cs);
		pls(2, `LLLC_EOC_OPEN);
		chk(u_analog_loop, 1'b1);
		pls(3, 4'h0);
		chk(u_analog_loop, 1'b0);
		axr(`LLLC_OFF_STATUS);
		chk(rd[7], 1'b1);
		$display("t_uloop done");
	endtask
	task t_eoc;
		eoc_auto <= 1'b1;
		u_transparent_state <= 1'b1;
		pls(2, `LLLC_EOC_ALL);
		chk(ds_ci_code, `LLLC_CODE_AIL);
		u_transparent_state <= 1'b0;
		pls(2, `LLLC_EOC_ALL);
		chk(ds_ci_code, `LLLC_CODE_ARL);
		eoc_auto <= 1'b0;
		pls(2, `LLLC_EOC_B1);
		pls(2, `LLLC_EOC_B2);
		axr(`LLLC_OFF_STATUS);
		chk(rd[2:0], 3'h6);
		pls(2, `LLLC_EOC_ALL);
		frm;
		chk(u_tx_b1, cu);
		pls(2, `LLLC_EOC_OPEN);
		axr(`LLLC_OFF_STATUS);
		chk(rd[2:0], 3'h0);
		pls(2, `LLLC_EOC_B1);
		axw(`LLLC_OFF_U_CTRL, 32'h0000_0002);
		axr(`LLLC_OFF_STATUS);
		chk(rd[2:0], 3'h0);
		$display("t_eoc done");
	endtask
	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end
	initial begin
		repeat (5000) @(posedge aclk);
		n_fail = n_fail + 1;
		conclude;
	end
	initial begin
		{n_fail, checks_done} = 64'h0;
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		s_axi_wstrb = 4'h1;
		{s_level_pin, u_reset, u_ci_valid, u_ci_code, s_ci_valid, s_ci_code} = 11'h000;
		{u_transparent_state, eoc_valid, eoc_code, eoc_auto} = 5'h00;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset;
		t_regloop;
		t_sloop;
		t_uloop;
		t_eoc;
		conclude;
	end
endmodule // lllc_top_tb
`default_nettype wire
